//--- src/idt_pkg.sv
// Package for the instruction decode and sequencing block
package idt_pkg;
   // Opcodes
   localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_BASE = 8'hE8;
   localparam logic [7:0] OP_JB_BASE = 8'h12;
   localparam logic [7:0] OP_XRD_BASE = 8'h80;
   localparam logic [7:0] OP_XWR_BASE = 8'h90;
   localparam logic [7:0] OP_RET_ST = 8'h93;
   localparam logic [7:0] OP_LK3 = 8'hE3;
   localparam logic [7:0] OP_LKC = 8'hA3;
   localparam logic [7:0] OP_STIM_BASE = 8'hB0;
   localparam logic [7:0] OP_LDI_BASE = 8'hB8;
   localparam logic [7:0] OP_XCHI_BASE = 8'h20;
   localparam logic [7:0] OP_NIB_BASE = 8'h30;
   localparam logic [7:0] OP_RB0 = 8'hC5;
   localparam logic [7:0] OP_RB1 = 8'hD5;
   localparam logic [7:0] OP_MB0 = 8'hE5;
   localparam logic [7:0] OP_MB1 = 8'hF5;
   localparam logic [7:0] OP_CLKO = 8'h75;
   localparam logic [7:0] OP_STRT_T = 8'h55;
   localparam logic [7:0] OP_STRT_C = 8'h45;
   localparam logic [7:0] OP_STOP = 8'h65;
   localparam logic [7:0] OP_TIE_EN = 8'h25;
   localparam logic [7:0] OP_TIE_DIS = 8'h35;
   localparam logic [7:0] OP_CLR_C = 8'h97;
   localparam logic [7:0] OP_CPL_C = 8'hA7;
   localparam logic [7:0] OP_CLR_FA = 8'h85;
   localparam logic [7:0] OP_CPL_FA = 8'h95;
   localparam logic [7:0] OP_CLR_FB = 8'hA5;
   localparam logic [7:0] OP_CPL_FB = 8'hB5;
   localparam logic [7:0] OP_JFA = 8'hB6;
   localparam logic [7:0] OP_JFB = 8'h76;
   localparam logic [7:0] MASK_REG = 8'hF8;
   localparam logic [7:0] MASK_IND = 8'hFE;
   localparam logic [7:0] MASK_JB = 8'h1F;
   localparam logic [1:0] PAGE_THREE = 2'h3;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [3:0] STAT_RESET = 4'h0;

   typedef enum logic [1:0] {
      IDT_FETCH = 2'b00,
      IDT_SECOND = 2'b01
   } idt_state_e;

   // External data memory request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } idt_xmem_s;

   // Internal data memory request
   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [7:0] wdata;
   } idt_imem_s;

   // Status of the decoder
   typedef struct packed {
      logic reg_bank;
      logic prog_bank;
      logic carry;
      logic user_flag_a;
      logic user_flag_b;
      logic clk_out_en;
      logic tmr_run;
      logic tmr_count_ext;
      logic tmr_int_en;
   } idt_stat_s;
endpackage

//--- src/idt_decode.sv
// Instruction decoder and sequencer for the 8-bit microcomputer core
`timescale 1ns/100ps
module idt_decode
   import idt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] prog_data,
   input wire logic [7:0] xmem_rdata,
   input wire logic [7:0] imem_rdata,
   input wire logic [10:0] stack_addr,
   input wire logic [3:0] stack_status,
   output logic [10:0] prog_addr,
   output idt_pkg::idt_xmem_s xmem,
   output idt_pkg::idt_imem_s imem,
   output logic stack_pop,
   output logic [7:0] acc,
   output idt_pkg::idt_stat_s stat,
   output logic instr_done,
   output logic [1:0] instr_cycles
);
   import idt_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   idt_state_e state;
   logic [10:0] pc;
   logic [7:0] opcode;
   logic [1:0] cyc_cnt;
   logic [7:0] regs [0:15];

   function automatic logic op_is(input logic [7:0] op, input logic [7:0] base,
                                  input logic [7:0] mask);
      op_is = (op & mask) == base;
   endfunction

   function automatic logic [3:0] reg_index(input logic bank, input logic [2:0] r);
      reg_index = {bank, r};
   endfunction

   // ----------------------------------------
   // Decode of the fetched byte
   // ----------------------------------------
   wire logic [7:0] op = (state == IDT_FETCH) ? prog_data : opcode;
   wire logic is_decrement_branch_nonzero = op_is(op, OP_DECREMENT_BRANCH_NONZERO_BASE, MASK_REG);
   wire logic is_jb = op_is(op, OP_JB_BASE, MASK_JB);
   wire logic is_xrd = op_is(op, OP_XRD_BASE, MASK_IND);
   wire logic is_xwr = op_is(op, OP_XWR_BASE, MASK_IND);
   wire logic is_ret = op == OP_RET_ST;
   wire logic is_lk3 = op == OP_LK3;
   wire logic is_lkc = op == OP_LKC;
   wire logic is_stim = op_is(op, OP_STIM_BASE, MASK_IND);
   wire logic is_ldi = op_is(op, OP_LDI_BASE, MASK_REG);
   wire logic is_xchi = op_is(op, OP_XCHI_BASE, MASK_IND);
   wire logic is_nib = op_is(op, OP_NIB_BASE, MASK_IND);
   wire logic is_jfa = op == OP_JFA;
   wire logic is_jfb = op == OP_JFB;
   wire logic two_byte = is_decrement_branch_nonzero | is_jb | is_stim | is_ldi | is_jfa | is_jfb;
   wire logic two_cyc = two_byte | is_xrd | is_xwr | is_ret | is_lk3 | is_lkc;
   wire logic [3:0] sel_reg = reg_index(stat.reg_bank, op[2:0]);
   wire logic [3:0] ptr_reg = reg_index(stat.reg_bank, {2'b00, op[0]});
   wire logic [7:0] ptr_val = regs[ptr_reg];
   wire logic [7:0] dec_val = regs[sel_reg] - BYTE_ONE;
   wire logic in_second = state == IDT_SECOND;
   // Branch target keeps bank and page bits; byte two supplies the low byte
   wire logic take_branch = (is_decrement_branch_nonzero & (dec_val != 8'h00))
                          | (is_jb & acc[opcode[7:5]])
                          | (is_jfa & stat.user_flag_a) | (is_jfb & stat.user_flag_b);
   // Lookups place the accumulator in the low byte of the selected page
   wire logic [10:0] lookup_addr = is_lk3 ? {1'b0, PAGE_THREE, acc}
                                          : {pc[10:8], acc};

   // ----------------------------------------
   // Program sequencing
   // ----------------------------------------
   logic [10:0] next_pc;
   always_comb
   begin
      next_pc = pc + 11'h001;
      if (in_second && is_ret)
         next_pc = stack_addr;
      else if (in_second && (is_lk3 || is_lkc || is_xrd || is_xwr))
         next_pc = pc;
      else if (in_second && take_branch)
         next_pc = {pc[10:8], prog_data};
   end

   assign prog_addr = (in_second && (is_lk3 || is_lkc)) ? lookup_addr : pc;
   assign stack_pop = in_second && is_ret;
   assign instr_done = (state == IDT_FETCH) ? !two_cyc : 1'b1;
   assign instr_cycles = cyc_cnt;

   // External memory strobes in the second cycle only
   assign xmem.rd = in_second && is_xrd;
   assign xmem.wr = in_second && is_xwr;
   assign xmem.addr = ptr_val;
   assign xmem.wdata = acc;

   // Internal data memory: immediate store, exchange, nibble exchange
   assign imem.addr = ptr_val[5:0];
   assign imem.we = (in_second && is_stim) || (!in_second && (is_xchi || is_nib));
   assign imem.wdata = is_stim ? prog_data
                     : is_nib ? {imem_rdata[7:4], acc[3:0]} : acc;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= IDT_FETCH;
         pc <= PC_RESET;
         opcode <= 8'h00;
         cyc_cnt <= 2'h0;
         acc <= 8'h00;
         stat <= '0;
      end
      else
      begin
         pc <= next_pc;
         if (state == IDT_FETCH)
         begin
            opcode <= prog_data;
            cyc_cnt <= two_cyc ? CYC_TWO : CYC_ONE;
            state <= two_cyc ? IDT_SECOND : IDT_FETCH;
            if (is_xchi)
               acc <= imem_rdata;
            if (is_nib)
               acc <= {acc[7:4], imem_rdata[3:0]};
            case (prog_data)
               OP_RB0: stat.reg_bank <= 1'b0;
               OP_RB1: stat.reg_bank <= 1'b1;
               OP_MB0: stat.prog_bank <= 1'b0;
               OP_MB1: stat.prog_bank <= 1'b1;
               OP_CLKO: stat.clk_out_en <= 1'b1;
               OP_STRT_T:
               begin
                  stat.tmr_run <= 1'b1;
                  stat.tmr_count_ext <= 1'b0;
               end
               OP_STRT_C:
               begin
                  stat.tmr_run <= 1'b1;
                  stat.tmr_count_ext <= 1'b1;
               end
               OP_STOP: stat.tmr_run <= 1'b0;
               OP_TIE_EN: stat.tmr_int_en <= 1'b1;
               OP_TIE_DIS: stat.tmr_int_en <= 1'b0;
               OP_CLR_C: stat.carry <= 1'b0;
               OP_CPL_C: stat.carry <= !stat.carry;
               OP_CLR_FA: stat.user_flag_a <= 1'b0;
               OP_CPL_FA: stat.user_flag_a <= !stat.user_flag_a;
               OP_CLR_FB: stat.user_flag_b <= 1'b0;
               OP_CPL_FB: stat.user_flag_b <= !stat.user_flag_b;
               default: stat <= stat;
            endcase
         end
         else
         begin
            state <= IDT_FETCH;
            if (is_xrd)
               acc <= xmem_rdata;
            if (is_lk3 || is_lkc)
               acc <= prog_data;
            if (is_ret)
            begin
               // Restores carry, both flags and register bank
               stat.carry <= stack_status[3];
               stat.user_flag_a <= stack_status[2];
               stat.reg_bank <= stack_status[1];
               stat.user_flag_b <= stack_status[0];
            end
         end
      end
   end

   // Register file has no reset; software loads before use
   always_ff @(posedge clk)
   begin
      if (!rst && in_second && is_decrement_branch_nonzero)
         regs[sel_reg] <= dec_val;
      if (!rst && in_second && is_ldi)
         regs[sel_reg] <= prog_data;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_two_cycle_len: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && two_cyc) |=> (in_second && instr_done) ##1 state == IDT_FETCH)
      else $error("two-cycle instruction length wrong");
   a_xrd_strobe: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && is_xrd) |=> xmem.rd ##1 !xmem.rd)
      else $error("external read strobe wrong");
   a_xwr_strobe: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && is_xwr) |=> xmem.wr && xmem.wdata == acc)
      else $error("external write strobe wrong");
   a_one_cycle: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_STOP) |-> instr_done ##1 !stat.tmr_run)
      else $error("stop not single cycle");
   a_count_src: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_STRT_C) |=> stat.tmr_count_ext && stat.tmr_run)
      else $error("counter source not external");
   a_bank_sel: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_RB1) |=> stat.reg_bank)
      else $error("register bank not selected");
   a_clk_out: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_CLKO) |=> stat.clk_out_en)
      else $error("clock output not enabled");
   a_ret_pop: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_ret) |=> pc == $past(stack_addr))
      else $error("return address not restored");
   a_lookup3: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_lk3) |-> prog_addr[9:8] == PAGE_THREE && prog_addr[7:0] == acc)
      else $error("page three lookup address wrong");

   // ----------------------------------------
   // Assertions per instruction group
   // ----------------------------------------
   a_decrement_branch_nonzero_taken: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_decrement_branch_nonzero && dec_val != 8'h00) |=> pc == $past({pc[10:8], prog_data}))
      else $error("decrement branch target wrong");
   a_decrement_branch_nonzero_fall: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_decrement_branch_nonzero && dec_val == 8'h00) |=> pc == $past(pc) + 11'h001)
      else $error("decrement branch fall through wrong");
   a_decrement_branch_nonzero_dec: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_decrement_branch_nonzero) |=> regs[$past(sel_reg)] == $past(dec_val))
      else $error("decrement branch register not decremented");
   a_jb_taken: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_jb && acc[opcode[7:5]]) |=> pc == $past({pc[10:8], prog_data}))
      else $error("accumulator bit branch not taken");
   a_jb_fall: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_jb && !acc[opcode[7:5]]) |=> pc == $past(pc) + 11'h001)
      else $error("accumulator bit branch taken on clear bit");
   a_xrd_data: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_xrd) |=> acc == $past(xmem_rdata))
      else $error("external read data not loaded");
   a_xwr_once: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && is_xwr) |=> xmem.wr ##1 !xmem.wr)
      else $error("external write strobe length wrong");
   a_ret_status: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_ret) |=> stat.carry == $past(stack_status[3])
         && stat.reg_bank == $past(stack_status[1]))
      else $error("return did not restore status");
   a_ret_pop_len: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && is_ret) |=> stack_pop ##1 !stack_pop)
      else $error("stack pop pulse wrong");
   a_lk3_data: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_lk3) |=> acc == $past(prog_data))
      else $error("page three lookup data not loaded");
   a_lkc_addr: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_lkc) |-> prog_addr == {pc[10:8], acc})
      else $error("current page lookup address wrong");
   a_lkc_data: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_lkc) |=> acc == $past(prog_data))
      else $error("current page lookup data not loaded");
   a_stim_write: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_stim) |-> imem.we && imem.wdata == prog_data)
      else $error("immediate store to data memory wrong");
   a_ldi_write: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_ldi) |=> regs[$past(sel_reg)] == $past(prog_data))
      else $error("immediate not loaded into register");
   a_xchg_acc: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && is_xchi) |-> instr_done && imem.we ##1 acc == $past(imem_rdata))
      else $error("exchange with data memory wrong");
   a_nibble_xchg: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && is_nib) |=> acc[7:4] == $past(acc[7:4])
         && acc[3:0] == $past(imem_rdata[3:0]))
      else $error("nibble exchange wrong");
   a_bank_zero: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_RB0) |=> !stat.reg_bank)
      else $error("register bank zero not selected");
   a_prog_bank_one: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_MB1) |=> stat.prog_bank)
      else $error("program bank one not selected");
   a_prog_bank_zero: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_MB0) |=> !stat.prog_bank)
      else $error("program bank zero not selected");
   a_timer_src: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_STRT_T) |=> stat.tmr_run && !stat.tmr_count_ext)
      else $error("timer start source wrong");
   a_tie_en: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_TIE_EN) |=> stat.tmr_int_en)
      else $error("timer interrupt not enabled");
   a_tie_dis: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_TIE_DIS) |=> !stat.tmr_int_en)
      else $error("timer interrupt not disabled");
   a_carry_clr: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_CLR_C) |=> !stat.carry)
      else $error("carry not cleared");
   a_carry_cpl: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_CPL_C) |=> stat.carry != $past(stat.carry))
      else $error("carry not complemented");
   a_flag_a_cpl: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_CPL_FA)
         |=> stat.user_flag_a != $past(stat.user_flag_a))
      else $error("user flag a not complemented");
   a_flag_b_cpl: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && prog_data == OP_CPL_FB)
         |=> stat.user_flag_b != $past(stat.user_flag_b))
      else $error("user flag b not complemented");
   a_flag_jump: assert property (@(posedge clk) disable iff (rst)
      (in_second && is_jfa && stat.user_flag_a) |=> pc == $past({pc[10:8], prog_data}))
      else $error("user flag jump not taken");
   a_one_byte_len: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && !two_cyc) |-> instr_done ##1 state == IDT_FETCH)
      else $error("single cycle instruction length wrong");
   a_cycle_two: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && two_cyc) |=> instr_cycles == CYC_TWO)
      else $error("two cycle count not reported");
   a_cycle_one: assert property (@(posedge clk) disable iff (rst)
      (state == IDT_FETCH && !two_cyc) |=> instr_cycles == CYC_ONE)
      else $error("one cycle count not reported");
endmodule

//--- testbench/idt_mem_model.sv
// Behavioural program, external data and internal data memories
`timescale 1ns/100ps
module idt_mem_model
   import idt_pkg::*;
(
   input wire logic clk,
   input wire logic [10:0] prog_addr,
   output logic [7:0] prog_data,
   input wire idt_pkg::idt_xmem_s xmem,
   output logic [7:0] xmem_rdata,
   input wire idt_pkg::idt_imem_s imem,
   output logic [7:0] imem_rdata
);
   logic [7:0] prog [0:2047] = '{default: 8'h00};
   logic [7:0] xm [0:255] = '{default: 8'h00};
   logic [7:0] im [0:63] = '{default: 8'h00};
   logic [7:0] last_rd = 8'h00;
   assign prog_data = prog[prog_addr];
   // Idle read bus shows the inverse of its last byte, so a late sample is caught
   assign xmem_rdata = xmem.rd ? xm[xmem.addr] : ~last_rd;
   assign imem_rdata = im[imem.addr];
   always @(posedge clk)
   begin
      if (xmem.rd) last_rd <= xm[xmem.addr];
      if (xmem.wr) xm[xmem.addr] <= xmem.wdata;
      if (imem.we) im[imem.addr] <= imem.wdata;
   end
endmodule

//--- testbench/mcu_instruction_decode_timing_tb_top.sv
// Self-checking testbench for the instruction decoder
`timescale 1ns/100ps
module mcu_instruction_decode_timing_tb_top;
   import idt_pkg::*;
   logic clk, rst, stack_pop, instr_done;
   logic [10:0] stack_addr, prog_addr;
   logic [3:0] stack_status;
   logic [7:0] prog_data, xmem_rdata, imem_rdata, acc;
   logic [1:0] instr_cycles;
   idt_xmem_s xmem, last_x;
   idt_imem_s imem, last_i;
   idt_stat_s stat;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_pop = 0;
   int i;
   logic [7:0] code [0:49] = '{8'hB8, 8'h05, 8'h80, 8'h90, 8'hE8, 8'h04, 8'h90, 8'h12, 8'h0B,
      8'h32, 8'h0D, 8'h00, 8'h00, 8'hA3, 8'hE3, 8'hB0, 8'h5A, 8'hB9, 8'h21, 8'h21, 8'h31,
      8'hD5, 8'hB8, 8'hAA, 8'h80, 8'hC5, 8'h80, 8'hF5, 8'hE5, 8'h75, 8'h45, 8'h65, 8'h55,
      8'h25, 8'h35, 8'h97, 8'hA7, 8'h95, 8'hB6, 8'h2A, 8'h00, 8'h00, 8'h85, 8'hB5, 8'h76,
      8'h30, 8'h00, 8'h00, 8'hA5, 8'h93};

   idt_decode dut_u (.clk(clk), .rst(rst), .prog_data(prog_data), .xmem_rdata(xmem_rdata),
      .imem_rdata(imem_rdata), .stack_addr(stack_addr), .stack_status(stack_status),
      .prog_addr(prog_addr), .xmem(xmem), .imem(imem), .stack_pop(stack_pop), .acc(acc),
      .stat(stat), .instr_done(instr_done), .instr_cycles(instr_cycles));
   idt_mem_model mem_u (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
      .xmem(xmem), .xmem_rdata(xmem_rdata), .imem(imem), .imem_rdata(imem_rdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Strobes last one cycle, so they are latched where they stand
   always @(negedge clk)
   begin
      if (xmem.rd | xmem.wr) last_x <= xmem;
      if (imem.we) last_i <= imem;
      if (stack_pop) n_pop <= n_pop + 1;
   end

   task chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Runs one instruction from its first cycle; checks length and next fetch address
   task automatic step(input logic [1:0] cyc, input logic [10:0] npc);
      int k;
      k = 1;
      while (instr_done !== 1'b1 && k < 5)
      begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      chk(k[23:0], {22'h0, cyc});
      chk(instr_cycles, cyc);
      chk(prog_addr, npc);
   endtask

   task summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #20000;
      n_mismatch++;
      summarize;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      stack_addr = 11'h123;
      stack_status = 4'hF;
      for (i = 0; i < 50; i++) mem_u.prog[i] = code[i];
      mem_u.prog[11'h042] = 8'h77;
      mem_u.prog[11'h377] = 8'h0C;
      mem_u.xm[8'h05] = 8'h42;
      mem_u.im[6'h21] = 8'h35;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk({5'h00, acc, prog_addr}, 24'h0);
      chk({15'h0000, stat}, 24'h0);
      step(2'h2, 11'h002);
      step(2'h2, 11'h003);
      chk({acc, last_x.addr}, 24'h4205);
      step(2'h2, 11'h004);
      chk({last_x.wr, last_x.addr, last_x.wdata}, 24'h10542);
      for (i = 0; i < 4; i++) step(2'h2, 11'h004);
      step(2'h2, 11'h006);
      step(2'h2, 11'h007);
      chk(last_x.addr, 24'h0);
      step(2'h2, 11'h009);
      step(2'h2, 11'h00D);
      step(2'h2, 11'h00E);
      chk(acc, 24'h77);
      step(2'h2, 11'h00F);
      chk(acc, 24'h0C);
      step(2'h2, 11'h011);
      chk(last_i, {1'b1, 6'h00, 8'h5A});
      step(2'h2, 11'h013);
      step(2'h1, 11'h014);
      chk({acc, last_i}, {8'h35, 1'b1, 6'h21, 8'h0C});
      step(2'h1, 11'h015);
      chk({acc, last_i}, {8'h3C, 1'b1, 6'h21, 8'h05});
      step(2'h1, 11'h016);
      step(2'h2, 11'h018);
      step(2'h2, 11'h019);
      chk({stat.reg_bank, last_x.addr}, 24'h1AA);
      step(2'h1, 11'h01A);
      step(2'h2, 11'h01B);
      chk({stat.reg_bank, last_x.addr}, 24'h0);
      step(2'h1, 11'h01C);
      chk(stat.prog_bank, 24'h1);
      step(2'h1, 11'h01D);
      chk(stat.prog_bank, 24'h0);
      step(2'h1, 11'h01E);
      chk(stat.clk_out_en, 24'h1);
      step(2'h1, 11'h01F);
      chk({stat.tmr_run, stat.tmr_count_ext}, 24'h3);
      step(2'h1, 11'h020);
      chk(stat.tmr_run, 24'h0);
      step(2'h1, 11'h021);
      chk({stat.tmr_run, stat.tmr_count_ext}, 24'h2);
      step(2'h1, 11'h022);
      chk(stat.tmr_int_en, 24'h1);
      step(2'h1, 11'h023);
      chk(stat.tmr_int_en, 24'h0);
      step(2'h1, 11'h024);
      chk(stat.carry, 24'h0);
      step(2'h1, 11'h025);
      chk(stat.carry, 24'h1);
      step(2'h1, 11'h026);
      chk(stat.user_flag_a, 24'h1);
      step(2'h2, 11'h02A);
      step(2'h1, 11'h02B);
      step(2'h1, 11'h02C);
      chk({stat.user_flag_a, stat.user_flag_b}, 24'h1);
      step(2'h2, 11'h030);
      step(2'h1, 11'h031);
      chk(stat.user_flag_b, 24'h0);
      step(2'h2, 11'h123);
      chk(n_pop[23:0], 24'h1);
      chk({stat.carry, stat.user_flag_a, stat.user_flag_b, stat.reg_bank}, 24'hF);
      step(2'h1, 11'h124);
      summarize;
   end
endmodule
